/* include/psb_pkg.sv */
// Contract
// RL1: code 0 changes nothing; program address advances by one.
// RL2: code 1 loads program address from jump address register only.
// RL3: jump address register captures low eight data bus bits when written.
// RL4: code 2 jumps to return stack top; stack left untouched.
// RL5: code 3 jumps to the absolute long displacement value.
// RL6: code 4 pops the return stack; address advances normally.
// RL7: code 5 pushes current address plus one; address advances normally.
// RL8: code 6 jumps to stack top and pops it together.
// RL9: code 7 jumps relative by long displacement and pushes address plus one.
// RL10: code 10 branches relative when selected sense bit is clear.
// RL11: short displacement is signed, +17 to -20 octal locations.
// RL12: sense lines sampled at instruction start; high level means clear.
// RL13: external devices drive eight active-low sense lines, low means set.
// RL14: code 11 branches when selected sense bit is set (line low).
// RL15: code 12 branches when selected internal flag bit is clear.
// RL16: code 13 branches when selected internal flag bit is set.
// RL17: code 14 branches when selected internal status bit is zero.
// RL18: status index: valid, full, R shift, Q shift, carry, zero, sign, overflow.
// RL19: status bits 2 to 7 readable in the control register.
// RL20: true condition adds short displacement; false advances by one.
// RL21: internal flags are an eight-bit register written by instruction fields.
// RL22: return stack is LIFO; depth sixteen, wraps, sticky overflow/underflow.
package psb_pkg;
    localparam int ADDR_W      = 8;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W        = 4;
    localparam int CNT_W       = 5;

    localparam logic [3:0] CODE_NOP          = 4'h0;
    localparam logic [3:0] CODE_JUMP_AR      = 4'h1;
    localparam logic [3:0] CODE_JUMP_ST      = 4'h2;
    localparam logic [3:0] CODE_JUMP_ABS     = 4'h3;
    localparam logic [3:0] CODE_POP          = 4'h4;
    localparam logic [3:0] CODE_PUSH         = 4'h5;
    localparam logic [3:0] CODE_RETURN       = 4'h6;
    localparam logic [3:0] CODE_CALL_REL     = 4'h7;
    localparam logic [3:0] CODE_SENSE_CLEAR  = 4'h8;
    localparam logic [3:0] CODE_SENSE_SET    = 4'h9;
    localparam logic [3:0] CODE_FLAG_CLEAR   = 4'hA;
    localparam logic [3:0] CODE_FLAG_SET     = 4'hB;
    localparam logic [3:0] CODE_STATUS_CLEAR = 4'hC;

    localparam logic [7:0] OFS_FLAGS       = 8'h00;
    localparam logic [7:0] OFS_JUMP_ADDR   = 8'h04;
    localparam logic [7:0] OFS_SEQ_STATUS  = 8'h08;
    localparam logic [7:0] OFS_CONTROL     = 8'h0C;

    localparam int BIT_CNT_LO   = 8;
    localparam int BIT_OVERFLOW = 16;
    localparam int BIT_UNDERFLW = 17;
    localparam int CR_STATUS_LO = 2;

    localparam logic [7:0]       RST_ADDR  = 8'h00;
    localparam logic [7:0]       RST_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] ONE_ADDR = 8'h01;
    localparam logic [31:0]      ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] code;       // program address control field
        logic [7:0] long_disp;  // long_displacement
        logic [2:0] bit_index;  // condition bit select
        logic [4:0] short_disp; // short_displacement, signed
    } psb_instr_t;

    typedef struct packed {
        logic fifo_valid;
        logic fifo_full;
        logic r_shift_out;
        logic q_shift_out;
        logic alu_carry;
        logic alu_zero;
        logic alu_sign;
        logic alu_overflow;
    } psb_status_t;
endpackage : psb_pkg

/* rtl/psb_branch_unit.sv */
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module psb_branch_unit (
    input  wire logic                 ref_clk,        // 100 MHz clock
    input  wire logic                 rst,            // async reset, active high
    input  wire logic                 instr_valid,    // one instruction per cycle
    input  wire psb_pkg::psb_instr_t  instr,          // decoded fields
    input  wire logic [7:0]           sense_lines_n,  // sense_line_7_n..sense_line_0_n
    input  wire psb_pkg::psb_status_t status_in,      // fifo and alu status
    input  wire logic                 ar_load,        // data bus to jump address reg
    input  wire logic [15:0]          data_bus,       // internal data bus
    input  wire logic                 flag_write,     // flag update from other fields
    input  wire logic [2:0]           flag_index,     // flag bit to update
    input  wire logic                 flag_value,     // new flag value
    input  wire logic                 wb_cyc_i,       // wishbone cycle
    input  wire logic                 wb_stb_i,       // wishbone strobe
    input  wire logic                 wb_we_i,        // wishbone write
    input  wire logic [7:0]           wb_adr_i,       // byte address
    input  wire logic [3:0]           wb_sel_i,       // byte lanes
    input  wire logic [31:0]          wb_dat_i,       // write data
    output logic      [31:0]          wb_dat_o,       // read data
    output logic                      wb_ack_o,       // acknowledge
    output logic      [7:0]           program_address, // current address
    output logic      [7:0]           return_stack_top, // top of stack
    output logic                      branch_taken    // pulse, last branch taken
);
    logic [7:0]                   jump_address_reg;
    logic [7:0]                   flags;
    logic [7:0]                   stack_mem [psb_pkg::STACK_DEPTH];
    logic [psb_pkg::SP_W-1:0]     sp;
    logic [psb_pkg::CNT_W-1:0]    depth;
    logic                         stack_ovf;
    logic                         stack_unf;
    logic [7:0]                   next_pa;

    // bus decode
    wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // write commits on the edge at which the master sees ack
    wire wb_wr     = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire hit_flags = (wb_adr_i == psb_pkg::OFS_FLAGS);
    wire hit_jump  = (wb_adr_i == psb_pkg::OFS_JUMP_ADDR);
    wire hit_seq   = (wb_adr_i == psb_pkg::OFS_SEQ_STATUS);
    wire hit_ctl   = (wb_adr_i == psb_pkg::OFS_CONTROL);

    // instruction decode
    wire [3:0] code       = instr.code;
    wire is_jump_ar  = instr_valid & (code == psb_pkg::CODE_JUMP_AR);
    wire is_jump_st  = instr_valid & (code == psb_pkg::CODE_JUMP_ST);
    wire is_jump_abs = instr_valid & (code == psb_pkg::CODE_JUMP_ABS);
    wire is_pop      = instr_valid & (code == psb_pkg::CODE_POP);
    wire is_push     = instr_valid & (code == psb_pkg::CODE_PUSH);
    wire is_return   = instr_valid & (code == psb_pkg::CODE_RETURN);
    wire is_call     = instr_valid & (code == psb_pkg::CODE_CALL_REL);
    wire is_cond     = instr_valid & (code >= psb_pkg::CODE_SENSE_CLEAR)
                                   & (code <= psb_pkg::CODE_STATUS_CLEAR);
    wire do_push     = is_push | is_call;
    wire do_pop      = is_pop | is_return;

    // condition select
    wire [7:0] sense_bits  = ~sense_lines_n;
    wire [7:0] status_bits;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_status
            // RL18 status bit order
            assign status_bits[g] = status_in[7 - g];
        end
    endgenerate

    wire sel_sense  = (code == psb_pkg::CODE_SENSE_CLEAR) | (code == psb_pkg::CODE_SENSE_SET);
    wire sel_flag   = (code == psb_pkg::CODE_FLAG_CLEAR)  | (code == psb_pkg::CODE_FLAG_SET);
    // RL12 sense sampled now
    wire [7:0] cond_src = sel_sense ? sense_bits : (sel_flag ? flags : status_bits);
    wire cond_bit   = cond_src[instr.bit_index];
    wire want_set   = (code == psb_pkg::CODE_SENSE_SET) | (code == psb_pkg::CODE_FLAG_SET);
    // RL10 RL14 RL15 RL16 RL17 polarity
    wire cond_true  = is_cond & (cond_bit == want_set);

    // RL11 signed short displacement
    wire [7:0] short_ext = {{3{instr.short_disp[4]}}, instr.short_disp};
    wire [7:0] pa_plus1  = program_address + psb_pkg::ONE_ADDR;
    wire [7:0] stack_top = stack_mem[sp];

    always_comb begin
        next_pa = pa_plus1;
        // RL1 default advance
        if (is_jump_ar) begin
            // RL2 jump to register
            next_pa = jump_address_reg;
        end else if (is_jump_st | is_return) begin
            // RL4 RL8 jump to top
            next_pa = stack_top;
        end else if (is_jump_abs) begin
            // RL5 absolute jump
            next_pa = instr.long_disp;
        end else if (is_call) begin
            // RL9 relative call
            next_pa = program_address + instr.long_disp;
        end else if (cond_true) begin
            // RL20 taken branch
            next_pa = program_address + short_ext;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            program_address <= psb_pkg::RST_ADDR;
            branch_taken    <= 1'b0;
        end else begin
            if (instr_valid) begin
                program_address <= next_pa;
            end
            branch_taken <= cond_true;
        end
    end

    // RL3 low eight bits captured
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            jump_address_reg <= psb_pkg::RST_ADDR;
        end else if (ar_load) begin
            jump_address_reg <= data_bus[7:0];
        end else if (wb_wr & hit_jump) begin
            jump_address_reg <= wb_dat_i[7:0];
        end
    end

    // RL21 flag register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags <= psb_pkg::RST_FLAGS;
        end else if (flag_write) begin
            flags[flag_index] <= flag_value;
        end else if (wb_wr & hit_flags) begin
            flags <= wb_dat_i[7:0];
        end
    end

    // RL22 circular stack store
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            // RL7 push address plus one
            stack_mem[sp + 1'b1] <= pa_plus1;
        end
    end

    wire clr_ovf = wb_wr & hit_seq & wb_dat_i[psb_pkg::BIT_OVERFLOW];
    wire clr_unf = wb_wr & hit_seq & wb_dat_i[psb_pkg::BIT_UNDERFLW];
    wire full    = (depth == psb_pkg::CNT_W'(psb_pkg::STACK_DEPTH));
    wire empty   = (depth == '0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sp        <= '0;
            depth     <= '0;
            stack_ovf <= 1'b0;
            stack_unf <= 1'b0;
        end else begin
            if (do_push) begin
                sp <= sp + 1'b1;
                if (!full) begin
                    depth <= depth + 1'b1;
                end
            end else if (do_pop) begin
                // RL6 RL8 pop
                sp <= sp - 1'b1;
                if (!empty) begin
                    depth <= depth - 1'b1;
                end
            end
            // set wins over clear
            stack_ovf <= (do_push & full) | (stack_ovf & ~clr_ovf);
            stack_unf <= (do_pop & empty) | (stack_unf & ~clr_unf);
        end
    end

    assign return_stack_top = stack_top;

    // register read mux
    wire [31:0] seq_word = {14'h0000, stack_unf, stack_ovf, 3'h0, depth, program_address};
    // RL19 status in control register
    wire [31:0] ctl_word = {24'h000000, status_bits[7:psb_pkg::CR_STATUS_LO], 2'h0};
    wire [31:0] rd_word  = hit_flags ? {24'h000000, flags} :
                           hit_jump  ? {24'h000000, jump_address_reg} :
                           hit_seq   ? seq_word :
                           hit_ctl   ? ctl_word : psb_pkg::ZERO_WORD;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= psb_pkg::ZERO_WORD;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_word : psb_pkg::ZERO_WORD;
        end
    end

    // checks
    // RL1 no-op advance
    chk_noop_advance: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        instr_valid && code == psb_pkg::CODE_NOP |=> program_address == $past(program_address) + 8'h01)
        else $error("no-op did not advance address");

    // RL2 register jump
    chk_jump_ar_load: assert property (@(posedge ref_clk) disable iff (rst) // RL2
        is_jump_ar |=> program_address == $past(jump_address_reg))
        else $error("jump to address register wrong");

    // RL3 low byte
    chk_ar_low_byte: assert property (@(posedge ref_clk) disable iff (rst) // RL3
        ar_load |=> jump_address_reg == $past(data_bus[7:0]))
        else $error("jump address register not loaded from bus");

    // RL4 stack kept
    chk_jump_stack_keep: assert property (@(posedge ref_clk) disable iff (rst) // RL4
        is_jump_st |=> program_address == $past(stack_top) && sp == $past(sp) && depth == $past(depth))
        else $error("stack jump changed stack or missed top");

    // RL5 absolute jump
    chk_jump_absolute: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        is_jump_abs |=> program_address == $past(instr.long_disp))
        else $error("absolute jump wrong");

    // RL6 pop only
    chk_pop_advance: assert property (@(posedge ref_clk) disable iff (rst) // RL6
        is_pop |=> sp == $past(sp) - 4'h1 && program_address == $past(program_address) + 8'h01)
        else $error("pop wrong");

    // RL7 pushed value
    chk_push_value: assert property (@(posedge ref_clk) disable iff (rst) // RL7
        is_push |=> return_stack_top == $past(program_address) + 8'h01
                    && program_address == $past(program_address) + 8'h01)
        else $error("push wrong");

    // RL8 return pops
    chk_return_pop: assert property (@(posedge ref_clk) disable iff (rst) // RL8
        is_return |=> program_address == $past(stack_top) && sp == $past(sp) - 4'h1)
        else $error("return wrong");

    // RL9 relative call
    chk_call_relative: assert property (@(posedge ref_clk) disable iff (rst) // RL9
        is_call |=> program_address == $past(program_address) + $past(instr.long_disp)
                    && return_stack_top == $past(program_address) + 8'h01)
        else $error("call wrong");

    // RL12 sense polarity
    chk_sense_polarity: assert property (@(posedge ref_clk) disable iff (rst) // RL12
        instr_valid && sel_sense |=> branch_taken ==
            ($past(sense_lines_n[instr.bit_index]) == ($past(code) == psb_pkg::CODE_SENSE_CLEAR)))
        else $error("sense branch polarity wrong");

    // RL20 branch target
    chk_branch_target: assert property (@(posedge ref_clk) disable iff (rst) // RL20
        is_cond |=> program_address == ($past(cond_true)
            ? $past(program_address) + {{3{$past(instr.short_disp[4])}}, $past(instr.short_disp)}
            : $past(program_address) + 8'h01))
        else $error("conditional branch target wrong");

    // RL17 status clear
    chk_status_clear: assert property (@(posedge ref_clk) disable iff (rst) // RL17
        instr_valid && code == psb_pkg::CODE_STATUS_CLEAR |-> cond_true == !status_in[3'h7 - instr.bit_index])
        else $error("status branch condition wrong");

    // RL16 flag set
    chk_flag_branch: assert property (@(posedge ref_clk) disable iff (rst) // RL16
        instr_valid && sel_flag |-> cond_true == (flags[instr.bit_index] == (code == psb_pkg::CODE_FLAG_SET)))
        else $error("flag branch condition wrong");

    // RL10 sense clear
    chk_sense_clear: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        instr_valid && code == psb_pkg::CODE_SENSE_CLEAR
        |-> cond_true == sense_lines_n[instr.bit_index])
        else $error("sense clear branch wrong");

    // RL14 sense set
    chk_sense_set: assert property (@(posedge ref_clk) disable iff (rst) // RL14
        instr_valid && code == psb_pkg::CODE_SENSE_SET
        |-> cond_true == !sense_lines_n[instr.bit_index])
        else $error("sense set branch wrong");

    // RL15 flag clear
    chk_flag_clear: assert property (@(posedge ref_clk) disable iff (rst) // RL15
        instr_valid && code == psb_pkg::CODE_FLAG_CLEAR
        |-> cond_true == !flags[instr.bit_index])
        else $error("flag clear branch wrong");

    // RL11 short offset range
    chk_short_range: assert property (@(posedge ref_clk) disable iff (rst) // RL11
        is_cond
        |=> 8'(program_address - $past(program_address) + 8'h10) <= 8'h1F)
        else $error("short branch out of range");

    // RL18 status index order
    chk_status_order: assert property (@(posedge ref_clk) disable iff (rst) // RL18
        status_bits[0] == status_in.fifo_valid
        && status_bits[1] == status_in.fifo_full
        && status_bits[7] == status_in.alu_overflow)
        else $error("status index order wrong");

    // RL19 control register status
    chk_ctl_status: assert property (@(posedge ref_clk) disable iff (rst) // RL19
        ctl_word[7:psb_pkg::CR_STATUS_LO] == {status_in.alu_overflow, status_in.alu_sign,
            status_in.alu_zero, status_in.alu_carry, status_in.q_shift_out, status_in.r_shift_out})
        else $error("control register status wrong");

    // RL21 flag bit write
    chk_flag_update: assert property (@(posedge ref_clk) disable iff (rst) // RL21
        flag_write
        |=> flags[$past(flag_index)] == $past(flag_value))
        else $error("flag write lost");

    // RL3 bus write low byte
    chk_ar_bus_write: assert property (@(posedge ref_clk) disable iff (rst) // RL3
        wb_wr && hit_jump && !ar_load
        |=> jump_address_reg == $past(wb_dat_i[7:0]))
        else $error("jump address bus write lost");

    // RL22 depth bound
    chk_depth_bound: assert property (@(posedge ref_clk) disable iff (rst) // RL22
        depth <= psb_pkg::CNT_W'(psb_pkg::STACK_DEPTH))
        else $error("stack depth beyond limit");

    // RL22 overflow flag
    chk_overflow_set: assert property (@(posedge ref_clk) disable iff (rst) // RL22
        do_push && full
        |=> stack_ovf)
        else $error("overflow not flagged");

    // RL22 underflow flag
    chk_underflow_set: assert property (@(posedge ref_clk) disable iff (rst) // RL22
        do_pop && empty
        |=> stack_unf)
        else $error("underflow not flagged");

    // RL20 taken only on branch
    chk_taken_pulse: assert property (@(posedge ref_clk) disable iff (rst) // RL20
        !is_cond
        |=> !branch_taken)
        else $error("branch taken without branch");

endmodule : psb_branch_unit

/* tb/psb_sense_model.sv */
`timescale 1ns/1ps
module psb_sense_model (
    input  wire logic       drive_en,     // far side is presenting conditions
    input  wire logic [7:0] set_bits,     // conditions to present, 1 = set
    output logic      [7:0] sense_lines_n // active-low sense lines
);
    // low level presents a set bit
    // released lines sit at the pull-up level
    assign sense_lines_n = drive_en ? ~set_bits : 8'hFF;
endmodule : psb_sense_model

/* tb/tb_program_sequencer_branch_unit.sv */
`timescale 1ns/1ps
module tb_program_sequencer_branch_unit;
    typedef struct packed {
        logic [3:0] c;
        logic [7:0] ld;
        logic [2:0] ix;
        logic [4:0] sd;
        logic [7:0] sn;
        logic [7:0] st;
    } psb_row_t;
    logic                 ref_clk     = 1'b0;
    logic                 rst         = 1'b1;
    logic                 instr_valid = 1'b0;
    psb_pkg::psb_instr_t  instr       = '0;
    psb_pkg::psb_status_t status_in   = '0;
    logic                 drive_en    = 1'b0;
    logic [7:0]           set_bits    = 8'h00;
    logic [7:0]           sense_lines_n;
    logic                 ar_load     = 1'b0;
    logic [15:0]          data_bus    = 16'h0000;
    logic                 flag_write  = 1'b0;
    logic [2:0]           flag_index  = 3'h0;
    logic                 flag_value  = 1'b0;
    logic                 wb_cyc_i    = 1'b0;
    logic                 wb_stb_i    = 1'b0;
    logic                 wb_we_i     = 1'b0;
    logic [7:0]           wb_adr_i    = 8'h00;
    logic [3:0]           wb_sel_i    = 4'h0;
    logic [31:0]          wb_dat_i    = 32'h0000_0000;
    logic [31:0]          wb_dat_o;
    logic [31:0]          q_w;
    logic                 wb_ack_o;
    logic                 branch_taken;
    logic [7:0]           program_address;
    logic [7:0]           return_stack_top;
    psb_row_t             rows [0:39];
    int                   n_rows      = 0;
    logic [7:0]           m_pa        = 8'h00;
    logic [7:0]           m_ar        = 8'h00;
    logic [7:0]           m_flags     = 8'hA5;
    logic [7:0]           m_stk [$];
    logic                 m_tk        = 1'b0;
    int                   n_mismatch  = 0;
    int                   comparisons = 0;

    always #5 ref_clk = ~ref_clk;

    psb_branch_unit psb_branch_unit_i (
        .ref_clk, .rst, .instr_valid, .instr, .sense_lines_n, .status_in, .ar_load, .data_bus,
        .flag_write, .flag_index, .flag_value, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .program_address, .return_stack_top, .branch_taken
    );
    psb_sense_model psb_sense_model_i (.drive_en, .set_bits, .sense_lines_n);

    task automatic finish_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic wb(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= sel;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            $display("ERROR wb_ack_o expected 1 seen timeout");
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, 4'hF, adr, 32'h0000_0000, q);
        chk_val(what, exp, q);
    endtask : rd

    task automatic add(input psb_row_t r);
        rows[n_rows] = r;
        n_rows++;
    endtask : add

    task automatic run_code(input logic [3:0] c, input int n);
        for (int k = 0; k <= n; k++) begin
            @(posedge ref_clk);
            instr_valid <= (k < n);
            instr       <= '{c, 8'h00, 3'h0, 5'h00};
        end
    endtask : run_code

    function automatic logic [7:0] rev8(input logic [7:0] s);
        return {<<{s}};
    endfunction : rev8

    task automatic predict(input psb_row_t r);
        logic [7:0] nx;
        logic       cond;
        nx = m_pa + 8'h01;
        cond = 1'b0;
        case (r.c)
            4'h1: nx = m_ar;
            4'h2: nx = m_stk[$];
            4'h3: nx = r.ld;
            4'h4: void'(m_stk.pop_back());
            4'h5: m_stk.push_back(nx);
            4'h6: nx = m_stk.pop_back();
            4'h7: begin
                m_stk.push_back(nx);
                nx = m_pa + r.ld;
            end
            4'h8: cond = !r.sn[r.ix];
            4'h9: cond = r.sn[r.ix];
            4'hA: cond = !m_flags[r.ix];
            4'hB: cond = m_flags[r.ix];
            4'hC: cond = !r.st[r.ix];
            default: ;
        endcase
        m_tk = (r.c inside {[4'h8:4'hC]}) && cond;
        m_pa = m_tk ? m_pa + {{3{r.sd[4]}}, r.sd} : nx;
    endtask : predict

    task automatic run_rows();
        for (int k = 0; k <= n_rows; k++) begin
            @(posedge ref_clk);
            instr_valid <= (k < n_rows);
            if (k < n_rows) begin
                instr     <= '{rows[k].c, rows[k].ld, rows[k].ix, rows[k].sd};
                set_bits  <= rows[k].sn;
                drive_en  <= rows[k].c inside {4'h8, 4'h9};
                status_in <= psb_pkg::psb_status_t'(rev8(rows[k].st));
            end
            @(negedge ref_clk);
            if (k > 0) begin
                chk_val("program_address", {24'h0, m_pa}, {24'h0, program_address});
                chk_bit("branch_taken", m_tk, branch_taken);
                if (m_stk.size() > 0) chk_val("stack_top", {24'h0, m_stk[$]}, {24'h0, return_stack_top});
            end
            if (k < n_rows) predict(rows[k]);
        end
    endtask : run_rows

    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk_val("program_address", 32'h0000_0000, {24'h0, program_address});
        chk_bit("branch_taken", 1'b0, branch_taken);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            flag_write <= 1'b1;
            flag_index <= i[2:0];
            flag_value <= m_flags[i];
        end
        @(posedge ref_clk);
        flag_write <= 1'b0;
        rd(8'h00, 32'h0000_00A5, "flags");
        wb(1'b1, 4'hF, 8'h04, 32'hFFFF_FF77, q_w);
        wb(1'b1, 4'h0, 8'h04, 32'h0000_0011, q_w);
        wb(1'b1, 4'hF, 8'h10, 32'h0000_00FF, q_w);
        rd(8'h04, 32'h0000_0077, "jump_address_reg");
        rd(8'h10, 32'h0000_0000, "unmapped");
        @(posedge ref_clk);
        ar_load  <= 1'b1;
        data_bus <= 16'hAB3C;
        @(posedge ref_clk);
        ar_load <= 1'b0;
        m_ar = 8'h3C;
        rd(8'h04, 32'h0000_003C, "jump_address_reg");
        add('{4'h0, 8'h55, 3'h7, 5'h1F, 8'h00, 8'h00});
        add('{4'h1, 8'h99, 3'h2, 5'h05, 8'h00, 8'h00});
        add('{4'h5, 8'h00, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h5, 8'h00, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h7, 8'h10, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h2, 8'h00, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h4, 8'h00, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h6, 8'h00, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h3, 8'hF0, 3'h0, 5'h00, 8'h00, 8'h00});
        add('{4'h8, 8'h00, 3'h3, 5'h1F, 8'h00, 8'h00});
        add('{4'h8, 8'h00, 3'h3, 5'h1F, 8'h08, 8'h00});
        add('{4'h9, 8'h00, 3'h7, 5'h0F, 8'h80, 8'h00});
        add('{4'h9, 8'h00, 3'h0, 5'h0F, 8'hFE, 8'h00});
        add('{4'hA, 8'h00, 3'h1, 5'h10, 8'h00, 8'h00});
        add('{4'hA, 8'h00, 3'h0, 5'h10, 8'h00, 8'h00});
        add('{4'hB, 8'h00, 3'h2, 5'h03, 8'h00, 8'h00});
        add('{4'hB, 8'h00, 3'h3, 5'h03, 8'h00, 8'h00});
        for (int i = 13; i < 16; i++) add('{i[3:0], 8'h00, 3'h1, 5'h04, 8'h00, 8'h00});
        for (int i = 0; i < 8; i++) begin
            add('{4'hC, 8'h00, i[2:0], 5'h02, 8'h00, 8'h01 << i});
            add('{4'hC, 8'h00, i[2:0] + 3'h1, 5'h02, 8'h00, 8'h01 << i});
        end
        run_rows();
        rd(8'h08, {19'h0, 5'h01, m_pa}, "seq_status");
        @(posedge ref_clk);
        status_in <= '1;
        rd(8'h0C, 32'h0000_00FC, "control_reg");
        run_code(psb_pkg::CODE_PUSH, 17);
        rd(8'h08, {14'h0, 2'h1, 3'h0, 5'h10, m_pa + 8'h11}, "seq_status");
        wb(1'b1, 4'hF, 8'h08, 32'h0001_0000, q_w);
        run_code(psb_pkg::CODE_POP, 17);
        rd(8'h08, {14'h0, 2'h2, 3'h0, 5'h00, m_pa + 8'h22}, "seq_status");
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk_val("program_address", 32'h0000_0000, {24'h0, program_address});
        finish_test();
    end
endmodule : tb_program_sequencer_branch_unit
